//--- ldo_a_voltage_settings.sv
// regulator A-setting register bank with axi4-lite access
`timescale 1ns/1ps
`include "ldo_a_cfg.svh"
// What this block does
// - bit 7 chooses normal or sleep mode
// - regulator 1 code 5:0, 0.60 V plus 20 mV
// - regulator 2 code 5:0, same mapping
// - regulator 3 code 6:0, 0.90 V plus 20 mV
module ldo_a_voltage_settings #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    input  wire logic                   clkEn,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0]      awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]      araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // regulator analog control
    output logic [2:0]                  applyA,
    output logic                        reg1SleepSelA,
    output logic [5:0]                  reg1VoltageCodeA,
    output ldo_a_pkg::millivolt_t       reg1TargetMv,
    output logic                        reg2SleepSelA,
    output logic [5:0]                  reg2VoltageCodeA,
    output ldo_a_pkg::millivolt_t       reg2TargetMv,
    output logic                        reg3SleepSelA,
    output logic [6:0]                  reg3VoltageCodeA,
    output ldo_a_pkg::millivolt_t       reg3TargetMv
);
    ldo_a_pkg::byte_t setting1;
    ldo_a_pkg::byte_t setting2;
    ldo_a_pkg::byte_t setting3;
    logic [2:0]       selA;
    reg_access_if     acc ();

    function automatic ldo_a_pkg::millivolt_t to_mv(input ldo_a_pkg::millivolt_t base, input logic [6:0] code);
        to_mv = base + 12'(code) * `LDO_MV_STEP;
    endfunction

    axil_reg_port #(
        .ADDR_W (ADDR_W)
    ) axil_reg_port_inst (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clkEn    (clkEn),
        .awaddr   (awaddr),
        .awvalid  (awvalid),
        .awready  (awready),
        .wdata    (wdata),
        .wstrb    (wstrb),
        .wvalid   (wvalid),
        .wready   (wready),
        .bresp    (bresp),
        .bvalid   (bvalid),
        .bready   (bready),
        .araddr   (araddr),
        .arvalid  (arvalid),
        .arready  (arready),
        .rdata    (rdata),
        .rresp    (rresp),
        .rvalid   (rvalid),
        .rready   (rready),
        .acc      (acc.front)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // status is read only, so writes to it are refused
    assign acc.wrHit = (acc.wrIndex == `LDO_REG1_IDX) || (acc.wrIndex == `LDO_REG2_IDX) ||
                       (acc.wrIndex == `LDO_REG3_IDX) || (acc.wrIndex == `LDO_SEL_IDX);
    assign acc.rdHit = (acc.rdIndex == `LDO_REG1_IDX) || (acc.rdIndex == `LDO_REG2_IDX) ||
                       (acc.rdIndex == `LDO_REG3_IDX) || (acc.rdIndex == `LDO_SEL_IDX) ||
                       (acc.rdIndex == `LDO_STAT_IDX);

    always_comb begin
        unique case (acc.rdIndex)
            `LDO_REG1_IDX: acc.rdData = setting1;
            `LDO_REG2_IDX: acc.rdData = setting2;
            `LDO_REG3_IDX: acc.rdData = setting3;
            `LDO_SEL_IDX:  acc.rdData = {5'h00, selA};
            `LDO_STAT_IDX: acc.rdData = {2'h0, reg3SleepSelA, reg2SleepSelA, reg1SleepSelA, applyA};
            default:       acc.rdData = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    // reserved bit 6 is kept whole so software reads back what it wrote
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            setting1 <= `LDO_SETTING_RST;
            setting2 <= `LDO_SETTING_RST;
            setting3 <= `LDO_SETTING_RST;
        end else if (clkEn && acc.wrEn && acc.wrStrb) begin
            if (acc.wrIndex == `LDO_REG1_IDX) begin
                setting1 <= acc.wrData;
            end
            if (acc.wrIndex == `LDO_REG2_IDX) begin
                setting2 <= acc.wrData;
            end
            if (acc.wrIndex == `LDO_REG3_IDX) begin
                setting3 <= acc.wrData;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            selA <= `LDO_SEL_RST;
        end else if (clkEn && acc.wrEn && acc.wrStrb && acc.wrIndex == `LDO_SEL_IDX) begin
            selA <= acc.wrData[2:0];
        end
    end

    // ------------------------------------------------------------
    // regulator controls
    // ------------------------------------------------------------
    // a deselected regulator sees zeros, never a half-written set
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            applyA           <= 3'h0;
            reg1SleepSelA    <= 1'b0;
            reg1VoltageCodeA <= 6'h00;
            reg1TargetMv     <= 12'h000;
        end else if (clkEn) begin
            applyA           <= selA;
            reg1SleepSelA    <= selA[0] & setting1[`LDO_SLEEP_BIT];
            reg1VoltageCodeA <= selA[0] ? setting1[`LDO_CODE6_MSB:0] : 6'h00;
            reg1TargetMv     <= selA[0] ? to_mv(`LDO_MV_BASE_LOW, {1'b0, setting1[`LDO_CODE6_MSB:0]})
                                        : 12'h000;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg2SleepSelA    <= 1'b0;
            reg2VoltageCodeA <= 6'h00;
            reg2TargetMv     <= 12'h000;
        end else if (clkEn) begin
            reg2SleepSelA    <= selA[1] & setting2[`LDO_SLEEP_BIT];
            reg2VoltageCodeA <= selA[1] ? setting2[`LDO_CODE6_MSB:0] : 6'h00;
            reg2TargetMv     <= selA[1] ? to_mv(`LDO_MV_BASE_LOW, {1'b0, setting2[`LDO_CODE6_MSB:0]})
                                        : 12'h000;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg3SleepSelA    <= 1'b0;
            reg3VoltageCodeA <= 7'h00;
            reg3TargetMv     <= 12'h000;
        end else if (clkEn) begin
            reg3SleepSelA    <= selA[2] & setting3[`LDO_SLEEP_BIT];
            reg3VoltageCodeA <= selA[2] ? setting3[`LDO_CODE7_MSB:0] : 7'h00;
            reg3TargetMv     <= selA[2] ? to_mv(`LDO_MV_BASE_HIGH, setting3[`LDO_CODE7_MSB:0])
                                        : 12'h000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_write1_sleep;
        clkEn && acc.wrEn && acc.wrStrb && acc.wrIndex == `LDO_REG1_IDX && acc.wrData[`LDO_SLEEP_BIT] && selA[0];
    endsequence

    sequence s_two_live_edges;
        clkEn ##1 clkEn;
    endsequence

    a_sleep_reaches_out: assert property (
        (s_write1_sleep ##1 (clkEn && selA[0])) |=> reg1SleepSelA)
        else $error("sleep bit written but regulator 1 not in sleep");

    a_reg1_mv_map: assert property (
        applyA[0] |-> reg1TargetMv == `LDO_MV_BASE_LOW + 12'(reg1VoltageCodeA) * `LDO_MV_STEP)
        else $error("regulator 1 target does not match its code");

    a_reg2_mv_map: assert property (
        (applyA[1] && reg2VoltageCodeA == 6'h3f) |-> reg2TargetMv == `LDO_MV_TOP_LOW)
        else $error("regulator 2 top code not 1860 mV");

    a_reg3_mv_map: assert property (
        applyA[2] |-> (reg3TargetMv == `LDO_MV_BASE_HIGH + 12'(reg3VoltageCodeA) * `LDO_MV_STEP) &&
                      (reg3VoltageCodeA != 7'h7f || reg3TargetMv == `LDO_MV_TOP_HIGH))
        else $error("regulator 3 target does not match its code");

    a_reserved_kept: assert property (
        (clkEn && acc.wrEn && acc.wrStrb && acc.wrIndex == `LDO_REG2_IDX) |=>
            setting2[`LDO_RSVD_BIT] == $past(acc.wrData[`LDO_RSVD_BIT]))
        else $error("reserved bit not stored");

    a_deselect_quiet: assert property (
        !applyA[1] |-> !reg2SleepSelA && reg2VoltageCodeA == 6'h00 && reg2TargetMv == 12'h000)
        else $error("deselected regulator 2 still driven");

    a_select_tracks: assert property (
        (s_two_live_edges ##0 $changed(selA)) |=> applyA == $past(selA))
        else $error("apply flags lag the select register");

    a_freeze_holds: assert property (
        (!clkEn ##1 !clkEn) |-> $stable(reg3SleepSelA) && $stable(reg1TargetMv))
        else $error("outputs moved while clock enable low");
endmodule

//--- ldo_a_cfg.svh
// constants for the regulator A-setting register bank
`ifndef LDO_A_CFG_SVH
`define LDO_A_CFG_SVH

// register indices; byte address is four times the index
`define LDO_REG1_IDX   8'ha9
`define LDO_REG2_IDX   8'haa
`define LDO_REG3_IDX   8'hab
`define LDO_SEL_IDX    8'h00
`define LDO_STAT_IDX   8'h01
`define LDO_IDX_LSB    2
`define LDO_IDX_MSB    9

// field positions
`define LDO_SLEEP_BIT  7
`define LDO_RSVD_BIT   6
`define LDO_CODE6_MSB  5
`define LDO_CODE7_MSB  6

// reset values
`define LDO_SETTING_RST 8'h00
`define LDO_SEL_RST     3'h0

// voltage mapping in millivolts
`define LDO_MV_BASE_LOW  12'h258
`define LDO_MV_BASE_HIGH 12'h384
`define LDO_MV_STEP      12'h014
`define LDO_MV_TOP_LOW   12'h744
`define LDO_MV_TOP_HIGH  12'hd70

// bus answers
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

//--- ldo_a_pkg.sv
// shared types of the regulator A-setting register bank
package ldo_a_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [7:0] index_t;
    typedef logic [11:0] millivolt_t;
endpackage

//--- reg_access_if.sv
// carrier between the bus front end and the register bank
`timescale 1ns/1ps
interface reg_access_if;
    logic              wrEn;
    ldo_a_pkg::index_t wrIndex;
    ldo_a_pkg::byte_t  wrData;
    logic              wrStrb;
    logic              wrHit;
    ldo_a_pkg::index_t rdIndex;
    ldo_a_pkg::byte_t  rdData;
    logic              rdHit;

    modport front (output wrEn, wrIndex, wrData, wrStrb, rdIndex, input wrHit, rdData, rdHit);
    modport bank  (input wrEn, wrIndex, wrData, wrStrb, rdIndex, output wrHit, rdData, rdHit);
endinterface

//--- axil_reg_port.sv
// axi4-lite slave front end for the register bank
`timescale 1ns/1ps
`include "ldo_a_cfg.svh"
module axil_reg_port #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              clkEn,
    // write channels
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // read channels
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // register bank side
    reg_access_if.front            acc
);
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] awAddr;
    ldo_a_pkg::byte_t  wData;
    logic              wStrb0;
    logic              commit;

    // aligned and inside the decoded index range
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a[`LDO_IDX_LSB-1:0] == '0) && (a[ADDR_W-1:`LDO_IDX_MSB+1] == '0);
    endfunction

    // no new address or data while a response waits
    assign awready     = clkEn & ~awHeld & ~bvalid;
    assign wready      = clkEn & ~wHeld & ~bvalid;
    assign arready     = clkEn & ~rvalid;
    assign commit      = clkEn & awHeld & wHeld;
    assign acc.wrIndex = awAddr[`LDO_IDX_MSB:`LDO_IDX_LSB];
    assign acc.wrData  = wData;
    assign acc.wrStrb  = wStrb0;
    assign acc.wrEn    = commit & addr_ok(awAddr);
    assign acc.rdIndex = araddr[`LDO_IDX_MSB:`LDO_IDX_LSB];

    // ------------------------------------------------------------
    // write address and data, taken in either order
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            awAddr <= '0;
        end else if (clkEn) begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awAddr <= awaddr;
            end else if (commit) begin
                awHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wHeld  <= 1'b0;
            wData  <= '0;
            wStrb0 <= 1'b0;
        end else if (clkEn) begin
            if (wvalid && wready) begin
                wHeld  <= 1'b1;
                wData  <= wdata[7:0];
                wStrb0 <= wstrb[0];
            end else if (commit) begin
                wHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp  <= `AXI_RESP_OKAY;
        end else if (clkEn) begin
            if (commit) begin
                bvalid <= 1'b1;
                bresp  <= (addr_ok(awAddr) && acc.wrHit) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read: data captured at the address handshake
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= `AXI_RESP_OKAY;
        end else if (clkEn) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                if (addr_ok(araddr) && acc.rdHit) begin
                    rdata <= {24'h000000, acc.rdData};
                    rresp <= `AXI_RESP_OKAY;
                end else begin
                    rdata <= '0;
                    rresp <= `AXI_RESP_SLVERR;
                end
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- ldo_a_voltage_settings_tb.sv
// self-checking bench for the regulator A-setting register bank
`timescale 1ns/1ps
module ldo_a_voltage_settings_tb;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic                  core_clk  = 1'b0;
    logic                  resetn    = 1'b0;
    logic                  clkEn     = 1'b1;
    logic [11:0]           awaddr    = 12'h000;
    logic                  awvalid   = 1'b0;
    logic [31:0]           wdata     = 32'h0;
    logic [3:0]            wstrb     = 4'h1;
    logic                  wvalid    = 1'b0;
    logic                  bready    = 1'b0;
    logic [11:0]           araddr    = 12'h000;
    logic                  arvalid   = 1'b0;
    logic                  rready    = 1'b0;
    logic                  awready;
    logic                  wready;
    logic [1:0]            bresp;
    logic                  bvalid;
    logic                  arready;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  rvalid;
    logic [2:0]            applyA;
    logic [2:0]            sleepOut;
    logic [6:0]            codeOut [3];
    ldo_a_pkg::millivolt_t mvOut [3];
    logic [3:0]            strb      = 4'h1;
    int                    nFail     = 0;
    int                    numChecks = 0;
    int                    cycles    = 0;

    always #50 core_clk = ~core_clk;

    // ----------------------------------------
    // device under test
    // ----------------------------------------
    ldo_a_voltage_settings #(.ADDR_W(12)) ldo_a_voltage_settings_inst (
        .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .applyA(applyA),
        .reg1SleepSelA(sleepOut[0]), .reg1VoltageCodeA(codeOut[0][5:0]), .reg1TargetMv(mvOut[0]),
        .reg2SleepSelA(sleepOut[1]), .reg2VoltageCodeA(codeOut[1][5:0]), .reg2TargetMv(mvOut[1]),
        .reg3SleepSelA(sleepOut[2]), .reg3VoltageCodeA(codeOut[2]), .reg3TargetMv(mvOut[2])
    );
    // the 6-bit codes leave the top bit undriven; pin it so compares stay exact
    assign codeOut[0][6] = 1'b0;
    assign codeOut[1][6] = 1'b0;

    // ----------------------------------------
    // bus tasks and compare
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // handshakes are judged at the negedge; inputs only move at posedges
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awDone;
        logic wDone;
        logic bDone;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awDone = 1'b0;
        wDone = 1'b0;
        bDone = 1'b0;
        while (!bDone) begin
            @(negedge core_clk);
            if (!awDone && awready === 1'b1) awDone = 1'b1;
            if (!wDone && wready === 1'b1) wDone = 1'b1;
            if (bvalid === 1'b1) begin
                bDone = 1'b1;
                r = bresp;
            end
            @(posedge core_clk);
            if (awDone) awvalid <= 1'b0;
            if (wDone) wvalid <= 1'b0;
            if (bDone) bready <= 1'b0;
        end
    endtask

    task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic rDone;
        logic arDone;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rDone = 1'b0;
        arDone = 1'b0;
        while (!rDone) begin
            @(negedge core_clk);
            if (!arDone && arready === 1'b1) arDone = 1'b1;
            if (rvalid === 1'b1) begin
                rDone = 1'b1;
                d = rdata;
                r = rresp;
            end
            @(posedge core_clk);
            if (arDone || rDone) arvalid <= 1'b0;
            if (rDone) rready <= 1'b0;
        end
    endtask

    // writes select and the three settings, then checks readback, outputs, status
    task automatic apply(input logic [7:0] a0, a1, a2, input logic [2:0] sel);
        logic [7:0]  v [3];
        logic [7:0]  m;
        logic [11:0] b;
        logic [2:0]  sl;
        logic [31:0] d;
        logic [1:0]  r;
        v[0] = a0;
        v[1] = a1;
        v[2] = a2;
        sl = 3'h0;
        axiWrite(12'h000, {29'h0, sel}, r);
        chk(r, 32'h0);
        for (int i = 0; i < 3; i++) begin
            axiWrite(12'h2a4 + 12'(4 * i), {24'h0, v[i]}, r);
            chk(r, 32'h0);
        end
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 3; i++) begin
            m = (i < 2) ? 8'h3f : 8'h7f;
            b = (i < 2) ? 12'h258 : 12'h384;
            sl[i] = sel[i] & v[i][7];
            axiRead(12'h2a4 + 12'(4 * i), d, r);
            chk(d, {24'h0, v[i]});
            chk(sleepOut[i], sl[i]);
            chk(codeOut[i], sel[i] ? {24'h0, v[i] & m} : 32'h0);
            chk(mvOut[i], sel[i] ? {20'h0, b + 12'h014 * {4'h0, v[i] & m}} : 32'h0);
        end
        chk(applyA, sel);
        axiRead(12'h004, d, r);
        chk(d, {26'h0, sl, sel});
    endtask

    task automatic wrapUp;
        $display("checks=%0d mismatches=%0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // hang guard; full run is well under 5000 cycles
    // ----------------------------------------
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nFail++;
            wrapUp();
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            axiRead(12'h2a4 + 12'(4 * i), d, r);
            chk(d, 32'h0);
            chk(mvOut[i], 32'h0);
        end
        $display("test reset values done");
        apply(8'hff, 8'h40, 8'hff, 3'h0);
        apply(8'hff, 8'h40, 8'hff, 3'h7);
        apply(8'h00, 8'hbf, 8'h00, 3'h7);
        apply(8'h2a, 8'h95, 8'hd5, 3'h2);
        apply(8'h2a, 8'h95, 8'hd5, 3'h5);
        $display("test settings and selection done");
        axiWrite(12'h2b0, 32'hff, r);
        chk(r, 32'h2);
        axiRead(12'h2b0, d, r);
        chk(r, 32'h2);
        chk(d, 32'h0);
        axiWrite(12'h004, 32'h3f, r);
        chk(r, 32'h2);
        axiWrite(12'h2a5, 32'h11, r);
        chk(r, 32'h2);
        strb = 4'h0;
        axiWrite(12'h2a4, 32'h11, r);
        chk(r, 32'h0);
        strb = 4'h1;
        axiRead(12'h2a4, d, r);
        chk(d, 32'h2a);
        chk(r, 32'h0);
        $display("test refused accesses done");
        // requests must wait and outputs hold while the clock enable is low
        @(posedge core_clk);
        clkEn <= 1'b0;
        fork
            axiRead(12'h2ac, d, r);
            begin
                repeat (3) @(negedge core_clk);
                chk({awready, wready, arready}, 32'h0);
                chk(mvOut[2], 32'h0a28);
                @(posedge core_clk);
                clkEn <= 1'b1;
            end
        join
        chk(d, 32'hd5);
        chk(r, 32'h0);
        $display("test clock enable freeze done");
        wrapUp();
    end
endmodule
